/* logic/aidr_top.sv */
// read-only diagnostic record of the two-channel analog input module
//
// Contract
// - no diagnostic interrupt; channel errors light channel LED, and all errors enter the record
// - parameter error, range overflow and range underflow are detected and reported
// - record set 01h returns whole record, 00h only the first 4 bytes
// - object index 2F01h serves whole record, 2F00h the first 4 bytes
// - index 5005h; subindex 02h for summary up to 13h for timestamp
// - summary bits 0-4: module, internal, external, channel error, aux supply missing
// - summary bit 7 on parameterization error; bits 6 and 5 read zero
// - module info byte: class 0101b, bit 4 channel info present, rest reserved
// - second diagnostic byte: bit 3 buffer overflow, bit 4 communication error
// - channel kind byte reads 71h, analog input
// - diagnostic bits per channel byte reads 08h
// - channel count byte reads 02h
// - channel group byte: bit 0 group 0, bit 1 group 1 error
// - per-channel byte bit 0 on configuration or parameter assignment error
// - per-channel byte bit 6 on underflow, bit 7 on overflow
// - error bytes of channels 2 to 7 read 00h
// - a recorded diagnostic event captures the microsecond ticker into the timestamp
// - microsecond counter runs from power-on and wraps to zero after all ones
`timescale 1ns/1ps
module aidr_top (
  input  wire logic                 i_clk,          // core clock, 100 MHz
  input  wire logic                 i_rst_n,        // sync reset, active low
  input  wire logic                 i_req,          // read request, one cycle
  input  wire aidr_pkg::aidr_mode_t i_mode,         // record set, index or subindex
  input  wire logic [15:0]          i_index,        // record number or object index
  input  wire logic [7:0]           i_sub,          // subindex under index 5005h
  input  wire logic [4:0]           i_byte_off,     // byte within the selected object
  input  wire logic                 i_module_fail,  // module failure
  input  wire logic                 i_internal_err, // internal error
  input  wire logic                 i_external_err, // external error
  input  wire logic                 i_aux_missing,  // external auxiliary supply missing
  input  wire logic                 i_param_err,    // module parameterization error
  input  wire logic                 i_buf_ovf,      // internal diagnostics buffer overflow
  input  wire logic                 i_comm_err,     // internal communication error
  input  wire logic [1:0]           i_chan_cfg_err, // per-channel parameter error
  input  wire logic [1:0]           i_chan_under,   // per-channel range underflow
  input  wire logic [1:0]           i_chan_over,    // per-channel range overflow
  output logic                      o_ack,          // answer valid, one cycle
  output logic                      o_err,          // request hit no record byte
  output logic [7:0]                o_data,         // record byte read
  output logic [1:0]                o_chan_led,     // red channel error LEDs
  output logic                      o_mod_led       // red module error LED
);
  import aidr_pkg::*;

  // ****************************************************************
  // microsecond ticker
  // ****************************************************************
  logic [31:0] us_count;
  logic        us_tick;

  aidr_us_ticker u_ticker (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .o_us_count (us_count),
    .o_us_tick  (us_tick)
  );

  // ****************************************************************
  // error capture
  // ****************************************************************
  // flags mirror the live conditions: they clear once the cause is gone
  logic [7:0] err_summary;
  logic [7:0] diag_flags;
  logic [7:0] group_err;
  logic [7:0] chan_err [AIDR_NCH];
  logic [31:0] event_ts;

  logic [7:0] next_chan_err [AIDR_NCH];
  logic [AIDR_NCH-1:0] next_chan_any;

  genvar ch;
  generate
    for (ch = 0; ch < AIDR_NCH; ch++) begin : g_chan
      assign next_chan_err[ch] = {i_chan_over[ch],
                                  i_chan_under[ch],
                                  5'h00,
                                  i_chan_cfg_err[ch]};
      assign next_chan_any[ch] = |next_chan_err[ch];
    end
  endgenerate

  wire any_chan_err = |next_chan_any;
  wire any_param    = i_param_err | (|i_chan_cfg_err);

  wire [7:0] next_summary = {any_param,
                             2'b00,
                             i_aux_missing,
                             any_chan_err,
                             i_external_err,
                             i_internal_err,
                             i_module_fail};
  wire [7:0] next_diag  = {3'b000, i_comm_err, i_buf_ovf, 3'b000};
  wire [7:0] next_group = {6'h00, next_chan_any};

  // any flag rising counts as a new diagnostic event
  wire [7:0] rise_sum   = next_summary & ~err_summary;
  wire [7:0] rise_diag  = next_diag & ~diag_flags;
  wire [7:0] rise_ch0   = next_chan_err[0] & ~chan_err[0];
  wire [7:0] rise_ch1   = next_chan_err[1] & ~chan_err[1];
  wire       diag_event = |{rise_sum, rise_diag, rise_ch0, rise_ch1};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      err_summary <= AIDR_ZERO_BYTE;
      diag_flags  <= AIDR_ZERO_BYTE;
      group_err   <= AIDR_ZERO_BYTE;
      chan_err[0] <= AIDR_ZERO_BYTE;
      chan_err[1] <= AIDR_ZERO_BYTE;
      event_ts    <= AIDR_TS_RESET;
      o_chan_led  <= 2'b00;
      o_mod_led   <= 1'b0;
    end else begin
      err_summary <= next_summary;
      diag_flags  <= next_diag;
      group_err   <= next_group;
      chan_err[0] <= next_chan_err[0];
      chan_err[1] <= next_chan_err[1];
      o_chan_led  <= next_chan_any;
      o_mod_led   <= |next_summary;
      if (diag_event) begin
        event_ts <= us_count;
      end
    end
  end

  // ****************************************************************
  // record image
  // ****************************************************************
  logic [7:0] rec_byte [AIDR_REC_BYTES];

  assign rec_byte[AIDR_B_SUMMARY] = err_summary;
  assign rec_byte[AIDR_B_MODINFO] = AIDR_MODULE_INFO;
  assign rec_byte[AIDR_B_RSVD]    = AIDR_ZERO_BYTE;
  assign rec_byte[AIDR_B_DIAG]    = diag_flags;
  assign rec_byte[AIDR_B_KIND]    = AIDR_CHANNEL_KIND;
  assign rec_byte[AIDR_B_NBITS]   = AIDR_DIAG_BITS;
  assign rec_byte[AIDR_B_NCH]     = AIDR_CHANNELS;
  assign rec_byte[AIDR_B_GROUP]   = group_err;

  genvar rb;
  generate
    for (rb = 0; rb < 8; rb++) begin : g_chan_byte
      if (rb < AIDR_NCH) begin : g_live
        assign rec_byte[AIDR_B_CHAN0 + rb] = chan_err[rb];
      end else begin : g_unused
        assign rec_byte[AIDR_B_CHAN0 + rb] = AIDR_ZERO_BYTE;
      end
    end
    // timestamp least significant byte first
    for (rb = 0; rb < AIDR_TS_BYTES; rb++) begin : g_ts_byte
      assign rec_byte[AIDR_B_TS + rb] = event_ts[8*rb +: 8];
    end
  endgenerate

  // ****************************************************************
  // read access
  // ****************************************************************
  aidr_acc_if acc ();

  assign acc.mode     = i_mode;
  assign acc.index    = i_index;
  assign acc.sub      = i_sub;
  assign acc.byte_off = i_byte_off;

  aidr_access_decode u_decode (
    .acc (acc)
  );

  wire [7:0] rd_byte = acc.hit ? rec_byte[acc.idx] : AIDR_ZERO_BYTE;

  // reads have no side effect on the record
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ack  <= 1'b0;
      o_err  <= 1'b0;
      o_data <= AIDR_ZERO_BYTE;
    end else begin
      o_ack  <= i_req;
      o_err  <= i_req & ~acc.hit;
      if (i_req) begin
        o_data <= rd_byte;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // marks the first edge after reset, so $past never looks into reset
  logic pst_ok;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pst_ok <= 1'b0;
    end else begin
      pst_ok <= 1'b1;
    end
  end

  chan_led_a : assert property (pst_ok && $past(i_chan_over[0] | i_chan_under[0] |
                                                 i_chan_cfg_err[0]) |-> o_chan_led[0])
    else $error("channel 0 error did not light its LED");

  err_classes_a : assert property (pst_ok && $past(i_chan_cfg_err[1]) |->
                                   chan_err[1][AIDR_CH_CFG] && err_summary[AIDR_SUM_PARAM])
    else $error("parameter error not recorded");

  record_short_a : assert property (i_req && i_mode == AIDR_MODE_RECORD &&
                                    i_index == 16'h0000 && i_byte_off == 5'h04 |=>
                                    o_ack && o_err)
    else $error("short record set served beyond four bytes");

  record_full_a : assert property (i_req && i_mode == AIDR_MODE_RECORD &&
                                   i_index == 16'h0001 && i_byte_off == 5'h05 |=>
                                   o_ack && !o_err && o_data == 8'h08)
    else $error("full record set byte 5 wrong");

  index_full_a : assert property (i_req && i_mode == AIDR_MODE_INDEX &&
                                  i_index == 16'h2f01 && i_byte_off == 5'h00 |=>
                                  !o_err && o_data == $past(err_summary))
    else $error("index 2F01h byte 0 not the summary");

  index_short_a : assert property (i_req && i_mode == AIDR_MODE_INDEX &&
                                   i_index == 16'h2f00 && i_byte_off == 5'h13 |=> o_err)
    else $error("short index served a long byte");

  sub_kind_a : assert property (i_req && i_mode == AIDR_MODE_SUBINDEX &&
                                i_index == 16'h5005 && i_sub == 8'h06 &&
                                i_byte_off == 5'h00 |=> !o_err && o_data == 8'h71)
    else $error("subindex 06h does not read the channel kind");

  sub_rsvd_a : assert property (i_req && i_mode == AIDR_MODE_SUBINDEX &&
                                i_index == 16'h5005 && i_sub == 8'h0c &&
                                i_byte_off == 5'h00 |=> !o_err && o_data == 8'h00)
    else $error("unused channel byte not zero");

  summary_bits_a : assert property (pst_ok |-> err_summary[6:5] == 2'b00 &&
                                    err_summary[AIDR_SUM_AUXSUP] == $past(i_aux_missing) &&
                                    err_summary[AIDR_SUM_MODFAIL] == $past(i_module_fail))
    else $error("summary byte wrong");

  diag_rsvd_a : assert property (pst_ok |-> diag_flags[2:0] == 3'b000 &&
                                 diag_flags[AIDR_DIAG_COMM] == $past(i_comm_err))
    else $error("second diagnostic byte wrong");

  range_bits_a : assert property (pst_ok |->
                                  chan_err[1][AIDR_CH_OVER] == $past(i_chan_over[1]) &&
                                  chan_err[0][AIDR_CH_UNDER] == $past(i_chan_under[0]))
    else $error("range flags do not follow the channel");

  group_follow_a : assert property (group_err[1:0] == {|chan_err[1], |chan_err[0]} &&
                                    err_summary[AIDR_SUM_CHANNEL] == |group_err)
    else $error("group or summary channel bit out of step");

  stamp_capture_a : assert property (diag_event |=> event_ts == $past(us_count))
    else $error("timestamp not captured on event");

  ticker_wrap_a : assert property (us_tick && us_count == 32'hffff_ffff |=>
                                   us_count == 32'h0000_0000)
    else $error("ticker did not wrap to zero");

  ticker_rate_a : assert property (us_tick |=> !us_tick [*8])
    else $error("ticker pulses too often");

  fixed_info_a : assert property (rec_byte[AIDR_B_MODINFO] == 8'h15 &&
                                  rec_byte[AIDR_B_NCH] == 8'h02)
    else $error("fixed identification bytes wrong");

  cov_record_c : cover property (i_req && i_mode == AIDR_MODE_RECORD ##1 o_ack && !o_err);
  cov_event_c  : cover property (diag_event ##1 o_chan_led[1]);
  cov_sub_ts_c : cover property (i_req && i_mode == AIDR_MODE_SUBINDEX &&
                                 i_sub == 8'h13 ##1 o_ack && !o_err);

endmodule

/* logic/aidr_pkg.sv */
// constants and types of the analog input diagnostic record
package aidr_pkg;

  // ****************************************************************
  // access modes and request widths
  // ****************************************************************
  typedef enum logic [1:0] {
    AIDR_MODE_RECORD,
    AIDR_MODE_INDEX,
    AIDR_MODE_SUBINDEX
  } aidr_mode_t;

  localparam int AIDR_REC_BYTES   = 20;
  localparam int AIDR_SHORT_BYTES = 4;
  localparam int AIDR_NCH         = 2;
  localparam int AIDR_TS_BYTES    = 4;
  localparam int AIDR_OFF_W       = 5;

  // ****************************************************************
  // selectors of the three access paths
  // ****************************************************************
  localparam logic [7:0]  AIDR_DS_FULL    = 8'h01;
  localparam logic [7:0]  AIDR_DS_SHORT   = 8'h00;
  localparam logic [15:0] AIDR_IX_FULL    = 16'h2f01;
  localparam logic [15:0] AIDR_IX_SHORT   = 16'h2f00;
  localparam logic [15:0] AIDR_ECAT_INDEX = 16'h5005;
  localparam logic [7:0]  AIDR_SX_FIRST   = 8'h02;
  localparam logic [7:0]  AIDR_SX_LAST    = 8'h11;
  localparam logic [7:0]  AIDR_SX_TS      = 8'h13;

  // ****************************************************************
  // byte positions within the record
  // ****************************************************************
  localparam logic [4:0] AIDR_B_SUMMARY = 5'h00;
  localparam logic [4:0] AIDR_B_MODINFO = 5'h01;
  localparam logic [4:0] AIDR_B_RSVD    = 5'h02;
  localparam logic [4:0] AIDR_B_DIAG    = 5'h03;
  localparam logic [4:0] AIDR_B_KIND    = 5'h04;
  localparam logic [4:0] AIDR_B_NBITS   = 5'h05;
  localparam logic [4:0] AIDR_B_NCH     = 5'h06;
  localparam logic [4:0] AIDR_B_GROUP   = 5'h07;
  localparam logic [4:0] AIDR_B_CHAN0   = 5'h08;
  localparam logic [4:0] AIDR_B_TS      = 5'h10;

  // ****************************************************************
  // fixed contents, reset values and field positions
  // ****************************************************************
  localparam logic [7:0] AIDR_MODULE_INFO  = 8'h15;
  localparam logic [7:0] AIDR_CHANNEL_KIND = 8'h71;
  localparam logic [7:0] AIDR_DIAG_BITS    = 8'h08;
  localparam logic [7:0] AIDR_CHANNELS     = 8'h02;
  localparam logic [7:0] AIDR_ZERO_BYTE    = 8'h00;
  localparam logic [31:0] AIDR_TS_RESET    = 32'h0000_0000;

  localparam int AIDR_SUM_MODFAIL  = 0;
  localparam int AIDR_SUM_INTERNAL = 1;
  localparam int AIDR_SUM_EXTERNAL = 2;
  localparam int AIDR_SUM_CHANNEL  = 3;
  localparam int AIDR_SUM_AUXSUP   = 4;
  localparam int AIDR_SUM_PARAM    = 7;
  localparam int AIDR_DIAG_BUFOVF  = 3;
  localparam int AIDR_DIAG_COMM    = 4;
  localparam int AIDR_CH_CFG       = 0;
  localparam int AIDR_CH_UNDER     = 6;
  localparam int AIDR_CH_OVER      = 7;

  // ****************************************************************
  // microsecond ticker timing
  // ****************************************************************
  localparam int AIDR_US_NS         = 1000;
  localparam int AIDR_CLK_NS        = 10;
  localparam int AIDR_TICKS_PER_US  = (AIDR_US_NS + AIDR_CLK_NS - 1) / AIDR_CLK_NS;
  localparam int AIDR_PRE_W         = 7;
  localparam logic [6:0] AIDR_PRE_LAST = 7'(AIDR_TICKS_PER_US - 1);

endpackage

/* logic/aidr_acc_if.sv */
// carrier between the record top and its access decoder
`timescale 1ns/1ps
interface aidr_acc_if;
  import aidr_pkg::*;
  aidr_mode_t      mode;
  logic [15:0]     index;
  logic [7:0]      sub;
  logic [4:0]      byte_off;
  logic            hit;
  logic [4:0]      idx;

  modport req (output mode, output index, output sub, output byte_off,
               input hit, input idx);
  modport dec (input mode, input index, input sub, input byte_off,
               output hit, output idx);
endinterface

/* logic/aidr_us_ticker.sv */
// free-running microsecond ticker with its clock prescaler
`timescale 1ns/1ps
module aidr_us_ticker (
  input  wire logic        i_clk,      // core clock
  input  wire logic        i_rst_n,    // sync reset, active low
  output logic [31:0]      o_us_count, // microseconds since power-on
  output logic             o_us_tick   // one-cycle pulse per microsecond
);
  import aidr_pkg::*;

  logic [AIDR_PRE_W-1:0] pre;
  wire                   pre_wrap = (pre == AIDR_PRE_LAST);
  wire [AIDR_PRE_W-1:0]  next_pre = pre_wrap ? '0 : pre + 7'h01;
  // natural 32-bit overflow gives the wrap to zero
  wire [31:0]            next_us  = o_us_count + 32'h0000_0001;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre        <= '0;
      o_us_count <= AIDR_TS_RESET;
      o_us_tick  <= 1'b0;
    end else begin
      pre       <= next_pre;
      o_us_tick <= pre_wrap;
      if (pre_wrap) begin
        o_us_count <= next_us;
      end
    end
  end
endmodule

/* logic/aidr_access_decode.sv */
// maps a record-set, object-index or subindex request to a record byte
`timescale 1ns/1ps
module aidr_access_decode (
  aidr_acc_if.dec acc // request in, byte position out
);
  import aidr_pkg::*;

  wire full_ok  = ({27'h0, acc.byte_off} < AIDR_REC_BYTES);
  wire short_ok = ({27'h0, acc.byte_off} < AIDR_SHORT_BYTES);
  wire ts_ok    = ({27'h0, acc.byte_off} < AIDR_TS_BYTES);

  wire rec_hit = (acc.index[15:8] == 8'h00) &&
                 (((acc.index[7:0] == AIDR_DS_FULL) && full_ok) ||
                  ((acc.index[7:0] == AIDR_DS_SHORT) && short_ok));
  wire ix_hit  = ((acc.index == AIDR_IX_FULL) && full_ok) ||
                 ((acc.index == AIDR_IX_SHORT) && short_ok);
  wire sx_ecat = (acc.index == AIDR_ECAT_INDEX);
  wire sx_byte = sx_ecat && (acc.sub >= AIDR_SX_FIRST) && (acc.sub <= AIDR_SX_LAST) &&
                 (acc.byte_off == 5'h00);
  wire sx_ts   = sx_ecat && (acc.sub == AIDR_SX_TS) && ts_ok;
  wire [4:0] sx_idx = sx_ts ? AIDR_B_TS + acc.byte_off
                            : 5'(acc.sub - AIDR_SX_FIRST);

  always_comb begin
    acc.hit = 1'b0;
    acc.idx = 5'h00;
    unique case (acc.mode)
      AIDR_MODE_RECORD: begin
        acc.hit = rec_hit;
        acc.idx = rec_hit ? acc.byte_off : 5'h00;
      end
      AIDR_MODE_INDEX: begin
        acc.hit = ix_hit;
        acc.idx = ix_hit ? acc.byte_off : 5'h00;
      end
      AIDR_MODE_SUBINDEX: begin
        acc.hit = sx_byte || sx_ts;
        acc.idx = (sx_byte || sx_ts) ? sx_idx : 5'h00;
      end
      default: begin
        acc.hit = 1'b0;
        acc.idx = 5'h00;
      end
    endcase
  end
endmodule

/* tb/aidr_reader.sv */
// bus coupler model that reads the diagnostic record one byte at a time
`timescale 1ns/1ps
module aidr_reader (
  input  wire logic          i_clk,   // core clock
  input  wire logic          i_ack,   // answer valid
  input  wire logic          i_err,   // request missed
  input  wire logic [7:0]    i_data,  // byte read
  output logic               o_req,   // read request
  output aidr_pkg::aidr_mode_t o_mode, // access path
  output logic [15:0]        o_index, // record number or index
  output logic [7:0]         o_sub,   // subindex
  output logic [4:0]         o_off    // byte within object
);
  import aidr_pkg::*;
  initial begin
    o_req   = 1'b0;
    o_mode  = AIDR_MODE_RECORD;
    o_index = 16'h0000;
    o_sub   = 8'h00;
    o_off   = 5'h00;
  end
  // one pulse per read; index, subindex and offset are scrambled after release so nothing leans on stale values
  task automatic rd(input aidr_mode_t m, input logic [15:0] ix, input logic [7:0] sx,
                    input logic [4:0] off, output logic [7:0] d, output logic e,
                    output logic a);
    @(negedge i_clk);
    o_req   = 1'b1;
    o_mode  = m;
    o_index = ix;
    o_sub   = sx;
    o_off   = off;
    @(posedge i_clk);
    @(negedge i_clk);
    a       = i_ack;
    e       = i_err;
    d       = i_data;
    o_req   = 1'b0;
    o_index = ~ix;
    o_sub   = ~sx;
    o_off   = ~off;
  endtask
endmodule

/* tb/test_aidr_top.sv */
// self-checking bench of the diagnostic record
`timescale 1ns/1ps
module test_aidr_top;
  import aidr_pkg::*;
  logic i_clk, i_rst_n, req, ack, err, mod_led, hit;
  logic [12:0] ev;
  logic [15:0] index;
  logic [7:0]  sub, data, exp_d;
  logic [4:0]  off;
  logic [1:0]  chan_led;
  logic [39:0] fl, nf;
  logic [31:0] us, ts, seed;
  logic [6:0]  pre;
  logic [5:0]  dv;
  aidr_mode_t  mode;
  int          mismatches, num_checks;

  aidr_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_mode(mode),
    .i_index(index), .i_sub(sub), .i_byte_off(off), .i_module_fail(ev[0]),
    .i_internal_err(ev[1]), .i_external_err(ev[2]), .i_aux_missing(ev[3]),
    .i_param_err(ev[4]), .i_buf_ovf(ev[5]), .i_comm_err(ev[6]), .i_chan_cfg_err(ev[8:7]),
    .i_chan_under(ev[10:9]), .i_chan_over(ev[12:11]), .o_ack(ack), .o_err(err),
    .o_data(data), .o_chan_led(chan_led), .o_mod_led(mod_led));
  aidr_reader u_rdr (.i_clk(i_clk), .i_ack(ack), .i_err(err), .i_data(data), .o_req(req),
    .o_mode(mode), .o_index(index), .o_sub(sub), .o_off(off));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // flag bytes {ch1, ch0, group, second diag, summary}
  function automatic logic [39:0] flags_now(input logic [12:0] v);
    logic [1:0] ch;
    ch = v[8:7] | v[10:9] | v[12:11];
    return {v[12], v[10], 5'h00, v[8], v[11], v[9], 5'h00, v[7], 6'h00, ch, 3'h0, v[6],
            v[5], 3'h0, v[4] | (|v[8:7]), 2'h0, v[3], |ch, v[2:0]};
  endfunction

  function automatic logic [5:0] dec(input logic [1:0] m, input logic [15:0] ix,
                                     input logic [7:0] sx, input logic [4:0] o);
    if ((m == 2'd0 && ix == 16'h0001) || (m == 2'd1 && ix == 16'h2f01)) return {o < 5'd20, o};
    if ((m == 2'd0 && ix == 16'h0000) || (m == 2'd1 && ix == 16'h2f00)) return {o < 5'd4, o};
    if (m == 2'd2 && ix == 16'h5005 && o == 5'd0 && sx >= 8'h02 && sx <= 8'h11)
      return {1'b1, 5'(sx - 8'h02)};
    if (m == 2'd2 && ix == 16'h5005 && sx == 8'h13 && o < 5'd4) return {1'b1, 5'h10 + o};
    return 6'h00;
  endfunction

  function automatic logic [7:0] byte_of(input logic [4:0] p);
    case (p)
      5'h00:   return fl[7:0];
      5'h01:   return 8'h15;
      5'h03:   return fl[15:8];
      5'h04:   return 8'h71;
      5'h05:   return 8'h08;
      5'h06:   return 8'h02;
      5'h07:   return fl[23:16];
      5'h08:   return fl[31:24];
      5'h09:   return fl[39:32];
      5'h10:   return ts[7:0];
      5'h11:   return ts[15:8];
      5'h12:   return ts[23:16];
      5'h13:   return ts[31:24];
      default: return 8'h00;
    endcase
  endfunction

  // reference of the flags, ticker and timestamp, stepped on every rising edge
  always @(posedge i_clk) begin
    if (i_rst_n && req) begin
      dv    = dec(mode, index, sub, off);
      hit   = dv[5];
      exp_d = hit ? byte_of(dv[4:0]) : 8'h00;
    end
    if (!i_rst_n) begin
      pre = 7'h00;
      us  = 32'h0;
      ts  = 32'h0;
      fl  = 40'h0;
    end else begin
      nf = flags_now(ev);
      if (|(nf & ~fl)) ts = us;
      fl = nf;
      if (pre == 7'd99) begin
        pre = 7'h00;
        us  = us + 32'h1;
      end else begin
        pre = pre + 7'h01;
      end
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    num_checks = num_checks + 1;
    if (g !== x) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic rdchk(input aidr_mode_t m, input logic [15:0] ix, input logic [7:0] sx,
                       input logic [4:0] o);
    logic [7:0] d;
    logic       e;
    logic       a;
    u_rdr.rd(m, ix, sx, o, d, e, a);
    chk({7'h00, a}, 8'h01);
    chk({7'h00, e}, {7'h00, ~hit});
    chk(d, exp_d);
    chk({5'h00, mod_led, chan_led}, {5'h00, |fl[7:0], fl[17:16]});
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs about 1300 cycles
  initial begin
    #100_000;
    mismatches = mismatches + 1;
    end_of_test();
  end

  initial begin
    logic [15:0] ixs [8];
    logic [31:0] r;
    ixs = '{16'h0000, 16'h0001, 16'h0002, 16'h2f00, 16'h2f01, 16'h5005, 16'h0101, 16'h2f02};
    seed = 32'ha6ef16cf;
    ev = 13'h0000;
    i_rst_n = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    for (int i = 0; i < 20; i++) rdchk(AIDR_MODE_RECORD, 16'h0001, 8'h00, 5'(i));
    for (int i = 2; i < 20; i++) rdchk(AIDR_MODE_SUBINDEX, 16'h5005, 8'(i), 5'h00);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (i % 8 == 0) ev = 13'($random(seed) & $random(seed));
      rdchk(aidr_mode_t'(r[1:0]), ixs[r[28:26]], {3'h0, r[20:16]}, r[25:21]);
      if (i % 8 == 7) begin
        for (int j = 0; j < 4; j++) rdchk(AIDR_MODE_SUBINDEX, 16'h5005, 8'h13, 5'(j));
      end
    end
    end_of_test();
  end
endmodule
